// [rtl/tsg_top.sv]
// Time-slot gate settings registers with range and conflict checking.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RULE1] Hold exclusion offset from slot start, 0 to 0.1 s, 50 ns, reset zero.
// [RULE2] Hold exclusion duration within slot, 0 to 0.1 s, 50 ns, reset zero.
// [RULE3] Hold slot duration, 50 ns to 1 s, 50 ns steps, reset 100 us.
// [RULE4] Hold leading trim percentage, 0 to 100 percent, 0.1 steps, reset zero.
// [RULE5] Hold trailing trim percentage, 0 to 100 percent, 0.1 steps, reset zero.
// [RULE6] Out-of-range write is clipped to nearest limit and raises code -222.
// [RULE7] Setting write in average-only detect mode raises conflict code -221.
// [RULE8] Setting write while a list sequence runs raises conflict code -221.
// [RULE9] Slot duration times slot count above 1 s raises conflict -221.
// [RULE10] Reading any setting returns the value currently held.
// [RULE11] Hold slot count per burst, 1 to 16.
// [RULE12] Times stored as 50 ns tick counts, percentages as tenths.
// [RULE13] Conflicting write keeps old value; clipped write stores the limit.

module tsg_top (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [tsg_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [tsg_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        list_running,
    output logic                             average_only_detect,
    output logic [tsg_pkg::SLOT_W-1:0]       time_slot_ticks,
    output logic [tsg_pkg::EXCL_W-1:0]       excl_offset_ticks,
    output logic [tsg_pkg::EXCL_W-1:0]       excl_time_ticks,
    output logic [tsg_pkg::PCT_W-1:0]        slot_gate_start_pct,
    output logic [tsg_pkg::PCT_W-1:0]        slot_gate_end_pct,
    output logic [tsg_pkg::CNT_W-1:0]        slot_count,
    output logic [tsg_pkg::SLOT_W-1:0]       gate_start_ticks,
    output logic [tsg_pkg::SLOT_W-1:0]       gate_end_ticks,
    output logic [tsg_pkg::SLOT_W-1:0]       excl_end_ticks
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    localparam int IDX_TOP = tsg_pkg::IDX_LSB + tsg_pkg::IDX_W;

    logic                        aw_hold_q;
    logic [tsg_pkg::ADDR_W-1:0]  awaddr_q;
    logic                        w_hold_q;
    tsg_pkg::tsg_word_t          wdata_q;
    logic [3:0]                  wstrb_q;
    logic                        bvalid_q;
    logic [1:0]                  bresp_q;
    logic                        rvalid_q;
    tsg_pkg::tsg_word_t          rdata_q;
    logic [1:0]                  rresp_q;
    tsg_pkg::tsg_word_t          set_q [tsg_pkg::NSET];
    logic                        avg_q;
    logic [tsg_pkg::ST_ERR_W-1:0] err_q;
    logic [15:0]                 code_q;
    tsg_pkg::tsg_word_t          wmask;
    tsg_pkg::tsg_word_t          merged [tsg_pkg::NSET];
    tsg_pkg::tsg_word_t          clipped [tsg_pkg::NSET];
    logic [tsg_pkg::NSET-1:0]    clip_f;
    logic                        wr_go;
    logic [tsg_pkg::IDX_W-1:0]   wr_idx;
    logic                        wr_mapped;
    logic                        set_wr;
    logic                        store;
    tsg_pkg::tsg_word_t          cand_slot;
    tsg_pkg::tsg_word_t          cand_cnt;
    logic [63:0]                 prod;
    logic                        buf_big;
    logic                        conflict;
    logic [tsg_pkg::ST_ERR_W-1:0] ev;
    logic [tsg_pkg::ST_ERR_W-1:0] clr;
    logic [tsg_pkg::IDX_W-1:0]   rd_idx;
    logic                        rd_mapped;
    tsg_pkg::tsg_word_t          rd_word;
    logic [63:0]                 start_prod;
    logic [63:0]                 end_prod;

    // ---------------------------------------------------------------
    // AXI4-Lite write channels
    // ---------------------------------------------------------------
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    assign wr_go     = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_idx    = awaddr_q[tsg_pkg::IDX_LSB +: tsg_pkg::IDX_W];
    assign wr_mapped = (awaddr_q[tsg_pkg::ADDR_W-1:IDX_TOP] == '0);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= tsg_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? tsg_pkg::RESP_OKAY : tsg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Byte-lane merge and range clipping per setting
    // ---------------------------------------------------------------
    genvar gb;
    for (gb = 0; gb < 4; gb++) begin : g_mask
        assign wmask[8*gb +: 8] = {8{wstrb_q[gb]}};
    end

    genvar gi;
    for (gi = 0; gi < tsg_pkg::NSET; gi++) begin : g_set
        assign merged[gi] = (set_q[gi] & ~wmask) | (wdata_q & wmask);

        // [RULE6] Clip to limit.
        tsg_clip #(
            .LO (tsg_pkg::SET_MIN[gi]),
            .HI (tsg_pkg::SET_MAX[gi])
        ) u_clip (
            .val_in  (merged[gi]),
            .val_out (clipped[gi]),
            .clipped (clip_f[gi])
        );

        // [RULE12] Tick and tenth storage.
        // [RULE13] Keep on conflict.
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                set_q[gi] <= tsg_pkg::SET_RST[gi];
            end else if (store && wr_idx == tsg_pkg::IDX_W'(gi)) begin
                set_q[gi] <= clipped[gi];
            end
        end
    end

    // ---------------------------------------------------------------
    // Conflict checks
    // ---------------------------------------------------------------
    assign set_wr = wr_go && wr_mapped && (wr_idx < tsg_pkg::IDX_W'(tsg_pkg::NSET));

    always_comb begin
        cand_slot = (wr_idx == tsg_pkg::IDX_SLOT) ? clipped[tsg_pkg::IDX_SLOT]
                                                  : set_q[tsg_pkg::IDX_SLOT];
        cand_cnt  = (wr_idx == tsg_pkg::IDX_COUNT) ? clipped[tsg_pkg::IDX_COUNT]
                                                   : set_q[tsg_pkg::IDX_COUNT];
        prod      = 64'(cand_slot) * 64'(cand_cnt);
    end

    // [RULE9] Buffer size check.
    assign buf_big = ((wr_idx == tsg_pkg::IDX_SLOT) || (wr_idx == tsg_pkg::IDX_COUNT))
                     && (prod > 64'(tsg_pkg::SLOT_MAX_TICKS));

    // [RULE7] Average-only refusal.
    // [RULE8] List running refusal.
    assign conflict = avg_q || list_running || buf_big;

    // [RULE13] Store only clean writes.
    assign store = set_wr && !conflict;

    // ---------------------------------------------------------------
    // Sticky error flags and last error code
    // ---------------------------------------------------------------
    always_comb begin
        ev[0] = store && clip_f[wr_idx];
        ev[1] = set_wr && avg_q;
        ev[2] = set_wr && list_running;
        ev[3] = set_wr && buf_big;
        clr   = '0;
        if (wr_go && wr_mapped && wr_idx == tsg_pkg::IDX_STAT && wstrb_q[0]) begin
            clr = wdata_q[tsg_pkg::ST_ERR_W-1:0];
        end
    end

    // [RULE6] Clip and conflict flags, set wins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err_q <= '0;
        end else begin
            err_q <= (err_q & ~clr) | ev;
        end
    end

    // [RULE7] Conflict code, wins over clip code.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            code_q <= '0;
        end else if (ev[3:1] != '0) begin
            code_q <= tsg_pkg::ERR_CODE_CONFLICT;
        end else if (ev[0]) begin
            code_q <= tsg_pkg::ERR_CODE_CLIP;
        end else if (wr_go && wr_mapped && wr_idx == tsg_pkg::IDX_STAT && wstrb_q[0]
                     && wdata_q[tsg_pkg::ST_CODE_CLR]) begin
            code_q <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Detector mode control
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avg_q <= 1'b0;
        end else if (wr_go && wr_mapped && wr_idx == tsg_pkg::IDX_CTRL && wstrb_q[0]) begin
            avg_q <= wdata_q[tsg_pkg::CTRL_AVG_BIT];
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read channels
    // ---------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign rd_idx    = s_axi_araddr[tsg_pkg::IDX_LSB +: tsg_pkg::IDX_W];
    assign rd_mapped = (s_axi_araddr[tsg_pkg::ADDR_W-1:IDX_TOP] == '0);

    // [RULE10] Read back held values.
    always_comb begin
        rd_word = '0;
        case (rd_idx)
            tsg_pkg::IDX_CTRL: begin
                rd_word[tsg_pkg::CTRL_AVG_BIT] = avg_q;
            end
            tsg_pkg::IDX_STAT: begin
                rd_word = {code_q, 7'h0, list_running, 4'h0, err_q};
            end
            default: begin
                rd_word = set_q[rd_idx];
            end
        endcase
        if (!rd_mapped) begin
            rd_word = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= tsg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_mapped ? tsg_pkg::RESP_OKAY : tsg_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Setting outputs toward the gating logic
    // ---------------------------------------------------------------
    // [RULE3] Slot duration.
    assign time_slot_ticks     = set_q[tsg_pkg::IDX_SLOT][tsg_pkg::SLOT_W-1:0];
    // [RULE1] Exclusion offset.
    assign excl_offset_ticks   = set_q[tsg_pkg::IDX_EOFS][tsg_pkg::EXCL_W-1:0];
    // [RULE2] Exclusion duration.
    assign excl_time_ticks     = set_q[tsg_pkg::IDX_EDUR][tsg_pkg::EXCL_W-1:0];
    // [RULE4] Leading trim.
    assign slot_gate_start_pct = set_q[tsg_pkg::IDX_GSTART][tsg_pkg::PCT_W-1:0];
    // [RULE5] Trailing trim.
    assign slot_gate_end_pct   = set_q[tsg_pkg::IDX_GEND][tsg_pkg::PCT_W-1:0];
    // [RULE11] Slot count.
    assign slot_count          = set_q[tsg_pkg::IDX_COUNT][tsg_pkg::CNT_W-1:0];
    assign average_only_detect = avg_q;

    // ---------------------------------------------------------------
    // Derived gate window in ticks
    // ---------------------------------------------------------------
    always_comb begin
        start_prod = (64'(set_q[tsg_pkg::IDX_SLOT]) * 64'(set_q[tsg_pkg::IDX_GSTART]))
                     / 64'(tsg_pkg::PCT_MAX_TENTH);
        end_prod   = (64'(set_q[tsg_pkg::IDX_SLOT]) * 64'(set_q[tsg_pkg::IDX_GEND]))
                     / 64'(tsg_pkg::PCT_MAX_TENTH);
    end

    // [RULE4] Gate opens after trim.
    // [RULE5] Gate closes before trim.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_start_ticks <= '0;
            gate_end_ticks   <= tsg_pkg::SLOT_RST_TICKS[tsg_pkg::SLOT_W-1:0];
        end else begin
            gate_start_ticks <= start_prod[tsg_pkg::SLOT_W-1:0];
            gate_end_ticks   <= tsg_pkg::SLOT_W'(64'(set_q[tsg_pkg::IDX_SLOT]) - end_prod);
        end
    end

    // [RULE1] Exclusion window end.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            excl_end_ticks <= '0;
        end else begin
            excl_end_ticks <= tsg_pkg::SLOT_W'(set_q[tsg_pkg::IDX_EOFS]
                                               + set_q[tsg_pkg::IDX_EDUR]);
        end
    end

endmodule // tsg_top

`default_nettype wire

// [common/tsg_pkg.sv]
// Shared constants and types for the time-slot gate settings block.
`default_nettype none

package tsg_pkg;

    // ---------------------------------------------------------------
    // Time base and setting ranges
    // ---------------------------------------------------------------
    localparam int TICK_NS       = 50;
    localparam int SLOT_MIN_NS   = 50;
    localparam int SLOT_MAX_NS   = 1_000_000_000;
    localparam int SLOT_RST_NS   = 100_000;
    localparam int EXCL_MAX_NS   = 100_000_000;
    localparam int PCT_MAX_TENTH = 1000;
    localparam int COUNT_MIN     = 1;
    localparam int COUNT_MAX     = 16;

    typedef logic [31:0] tsg_word_t;

    localparam tsg_word_t SLOT_MIN_TICKS = tsg_word_t'(SLOT_MIN_NS / TICK_NS);
    localparam tsg_word_t SLOT_MAX_TICKS = tsg_word_t'(SLOT_MAX_NS / TICK_NS);
    localparam tsg_word_t SLOT_RST_TICKS = tsg_word_t'(SLOT_RST_NS / TICK_NS);
    localparam tsg_word_t EXCL_MAX_TICKS = tsg_word_t'(EXCL_MAX_NS / TICK_NS);

    // ---------------------------------------------------------------
    // Field widths
    // ---------------------------------------------------------------
    localparam int SLOT_W = 25;
    localparam int EXCL_W = 21;
    localparam int PCT_W  = 10;
    localparam int CNT_W  = 5;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W  = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_W   = 3;
    localparam int NSET    = 6;

    localparam logic [IDX_W-1:0] IDX_SLOT   = 3'h0;
    localparam logic [IDX_W-1:0] IDX_EOFS   = 3'h1;
    localparam logic [IDX_W-1:0] IDX_EDUR   = 3'h2;
    localparam logic [IDX_W-1:0] IDX_GSTART = 3'h3;
    localparam logic [IDX_W-1:0] IDX_GEND   = 3'h4;
    localparam logic [IDX_W-1:0] IDX_COUNT  = 3'h5;
    localparam logic [IDX_W-1:0] IDX_CTRL   = 3'h6;
    localparam logic [IDX_W-1:0] IDX_STAT   = 3'h7;

    localparam tsg_word_t SET_MIN [NSET] = '{SLOT_MIN_TICKS, 32'h0, 32'h0, 32'h0, 32'h0,
                                             tsg_word_t'(COUNT_MIN)};
    localparam tsg_word_t SET_MAX [NSET] = '{SLOT_MAX_TICKS, EXCL_MAX_TICKS, EXCL_MAX_TICKS,
                                             tsg_word_t'(PCT_MAX_TENTH),
                                             tsg_word_t'(PCT_MAX_TENTH),
                                             tsg_word_t'(COUNT_MAX)};
    localparam tsg_word_t SET_RST [NSET] = '{SLOT_RST_TICKS, 32'h0, 32'h0, 32'h0, 32'h0,
                                             tsg_word_t'(COUNT_MIN)};

    // Control and status fields.
    localparam int CTRL_AVG_BIT = 0;
    localparam int ST_ERR_W     = 4;
    localparam int ST_CODE_CLR  = 4;

    // Error codes as 16-bit two's complement: -222 and -221.
    localparam logic [15:0] ERR_CODE_CLIP     = 16'hff22;
    localparam logic [15:0] ERR_CODE_CONFLICT = 16'hff23;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tsg_pkg

`default_nettype wire

// [rtl/tsg_clip.sv]
// Range limiter that clips a written value to its permitted bounds.
`timescale 1ns/100ps
`default_nettype none

module tsg_clip #(
    parameter tsg_pkg::tsg_word_t LO = 32'h0,
    parameter tsg_pkg::tsg_word_t HI = 32'h0
) (
    input  wire logic [31:0] val_in,
    output logic      [31:0] val_out,
    output logic             clipped
);

    // ---------------------------------------------------------------
    // Clip to nearest limit
    // ---------------------------------------------------------------
    always_comb begin
        if (val_in > HI) begin
            val_out = HI;
            clipped = 1'b1;
        end else if (val_in < LO) begin
            val_out = LO;
            clipped = 1'b1;
        end else begin
            val_out = val_in;
            clipped = 1'b0;
        end
    end

endmodule // tsg_clip

`default_nettype wire

// [dv/tsg_monitor.sv]
// Port checks for the time-slot gate settings block.
`timescale 1ns/100ps
`default_nettype none

module tsg_monitor (
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic                       s_axi_rvalid,
    input wire logic                       list_running,
    input wire logic                       average_only_detect,
    input wire logic [tsg_pkg::SLOT_W-1:0] time_slot_ticks,
    input wire logic [tsg_pkg::EXCL_W-1:0] excl_offset_ticks,
    input wire logic [tsg_pkg::EXCL_W-1:0] excl_time_ticks,
    input wire logic [tsg_pkg::PCT_W-1:0]  slot_gate_start_pct,
    input wire logic [tsg_pkg::PCT_W-1:0]  slot_gate_end_pct,
    input wire logic [tsg_pkg::CNT_W-1:0]  slot_count
);
    logic [91:0] cfg;
    assign cfg = {time_slot_ticks, excl_offset_ticks, excl_time_ticks, slot_gate_start_pct,
                  slot_gate_end_pct, slot_count};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_slot_range: assert property (time_slot_ticks inside {[25'h1:25'h1312d00]})
        else $error("slot time out of range");
    a_excl_range: assert property (excl_offset_ticks <= 21'h1e8480 &&
        excl_time_ticks <= 21'h1e8480) else $error("exclusion time out of range");
    a_pct_range: assert property (slot_gate_start_pct <= 10'h3e8 &&
        slot_gate_end_pct <= 10'h3e8) else $error("trim out of range");
    a_count_range: assert property (slot_count inside {[5'h1:5'h10]})
        else $error("slot count out of range");
    a_buffer_limit: assert property (64'(time_slot_ticks) * slot_count <= 64'h1312d00)
        else $error("slot time times count too large");
    a_list_freeze: assert property (list_running |=> $stable(cfg))
        else $error("setting changed while list runs");
    a_avg_freeze: assert property (average_only_detect |=> $stable(cfg))
        else $error("setting changed in average mode");

    c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_list_write: cover property (list_running && s_axi_bvalid);
    c_avg_write: cover property (average_only_detect && s_axi_bvalid);
endmodule // tsg_monitor

bind tsg_top tsg_monitor u_mon (.*);

`default_nettype wire

// [dv/tsg_host_model.sv]
// Host model that issues register writes and reads over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module tsg_host_model (
    input  wire logic                        sys_clk,
    output logic [tsg_pkg::ADDR_W-1:0]       s_axi_awaddr,
    output logic                             s_axi_awvalid,
    input  wire logic                        s_axi_awready,
    output logic [31:0]                      s_axi_wdata,
    output logic                             s_axi_wvalid,
    input  wire logic                        s_axi_wready,
    input  wire logic [1:0]                  s_axi_bresp,
    input  wire logic                        s_axi_bvalid,
    output logic                             s_axi_bready,
    output logic [tsg_pkg::ADDR_W-1:0]       s_axi_araddr,
    output logic                             s_axi_arvalid,
    input  wire logic                        s_axi_arready,
    input  wire logic [31:0]                 s_axi_rdata,
    input  wire logic [1:0]                  s_axi_rresp,
    input  wire logic                        s_axi_rvalid,
    output logic                             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Released lines carry the inverse of their last value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic b;
        b = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b  = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge sys_clk);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid  <= s_axi_wvalid && !tw;
            s_axi_awaddr  <= ta ? ~a : s_axi_awaddr;
            s_axi_wdata   <= tw ? ~d : s_axi_wdata;
            s_axi_bready  <= !b;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic g;
        g = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!g) begin
            @(negedge sys_clk);
            ta = s_axi_arvalid && s_axi_arready;
            g  = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge sys_clk);
            s_axi_arvalid <= s_axi_arvalid && !ta;
            s_axi_araddr  <= ta ? ~a : s_axi_araddr;
            s_axi_rready  <= !g;
        end
    endtask
endmodule // tsg_host_model

`default_nettype wire

// [dv/tsg_top_bench.sv]
// Self-checking bench for the time-slot gate settings block.
`timescale 1ns/100ps
`default_nettype none

module tsg_top_bench;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] want;
        logic [15:0] code;
    } tsg_row_t;
    localparam tsg_row_t ROWS [16] = '{
        '{8'h00, 32'h64, 32'h64, 16'h0}, '{8'h04, 32'h186a0, 32'h186a0, 16'h0},
        '{8'h04, 32'hffffff, 32'h1e8480, 16'hff22}, '{8'h08, 32'h1e8480, 32'h1e8480, 16'h0},
        '{8'h08, 32'h1e8481, 32'h1e8480, 16'hff22}, '{8'h0c, 32'h64, 32'h64, 16'h0},
        '{8'h0c, 32'h3e9, 32'h3e8, 16'hff22}, '{8'h10, 32'h3e8, 32'h3e8, 16'h0},
        '{8'h14, 32'h10, 32'h10, 16'h0}, '{8'h14, 32'h0, 32'h1, 16'hff22},
        '{8'h14, 32'h11, 32'h10, 16'hff22}, '{8'h00, 32'h0, 32'h1, 16'hff22},
        '{8'h00, 32'h1312d00, 32'h1, 16'hff23}, '{8'h14, 32'h1, 32'h1, 16'h0},
        '{8'h00, 32'h1312d01, 32'h1312d00, 16'hff22}, '{8'h14, 32'h2, 32'h1, 16'hff23}};

    logic        sys_clk, rst, list_running, average_only_detect;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [24:0] time_slot_ticks, gate_start_ticks, gate_end_ticks, excl_end_ticks;
    logic [20:0] excl_offset_ticks, excl_time_ticks;
    logic [9:0]  slot_gate_start_pct, slot_gate_end_pct;
    logic [4:0]  slot_count;
    int          num_errors, tests_run;

    assign s_axi_wstrb = 4'hf;
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    tsg_top u_dut (.*);
    tsg_host_model u_host (.*);

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out;
        $display("compares %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        list_running = 1'b0;
        num_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            u_host.wr(8'h1c, 32'h1f, r);
            u_host.wr(ROWS[i].addr, ROWS[i].data, r);
            u_host.rd(ROWS[i].addr, d, r);
            chk(d, ROWS[i].want);
            u_host.rd(8'h1c, d, r);
            chk({16'h0, d[31:16]}, {16'h0, ROWS[i].code});
        end
        chk(32'(time_slot_ticks), 32'h1312d00);
        chk(32'(gate_start_ticks), 32'h1312d00);
        chk(32'(gate_end_ticks), 32'h0);
        chk(32'(excl_end_ticks), 32'h3d0900);
        $display("test table done");
        u_host.wr(8'h1c, 32'h1f, r);
        u_host.wr(8'h18, 32'h1, r);
        chk(32'(average_only_detect), 32'h1);
        u_host.wr(8'h0c, 32'h5, r);
        u_host.rd(8'h0c, d, r);
        chk(d, 32'h3e8);
        u_host.rd(8'h1c, d, r);
        chk(d & 32'hffff000f, 32'hff230002);
        u_host.wr(8'h18, 32'h0, r);
        u_host.wr(8'h1c, 32'h1f, r);
        $display("test average mode done");
        list_running <= 1'b1;
        u_host.wr(8'h10, 32'h7, r);
        u_host.rd(8'h10, d, r);
        chk(d, 32'h3e8);
        u_host.rd(8'h1c, d, r);
        chk(d & 32'hffff010f, 32'hff230104);
        list_running <= 1'b0;
        $display("test list running done");
        u_host.wr(8'h20, 32'h5, r);
        chk(32'(r), 32'h2);
        u_host.rd(8'h20, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        $display("test unmapped done");
        u_host.wr(8'h00, 32'h64, r);
        u_host.wr(8'h14, 32'h2, r);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            u_host.rd(8'(4 * i), d, r);
            chk(d, (i == 0) ? 32'h7d0 : (i == 5) ? 32'h1 : 32'h0);
        end
        chk(32'(gate_end_ticks), 32'h7d0);
        $display("test reset done");
        close_out();
    end
endmodule // tsg_top_bench

`default_nettype wire
